// *** verilog/asd_pkg.sv ***
/*
 Constants for the address space decoder: space sizes, region bounds,
 program memory layout, information area layout and the part string.
 Assumes an 8-bit core with a 12-bit register address and 16-bit program address.
*/
package asd_pkg;
    localparam int REG_AW = 12;
    localparam int PRG_AW = 16;
    localparam int DW = 8;
    localparam int REG_SPACE_BYTES = 4096;
    localparam logic [11:0] CTRL_PAGE_BASE = 12'hF00;
    localparam logic [11:0] CTRL_PAGE_TOP = 12'hFFF;
    localparam int CTRL_PAGE_BYTES = 256;
    localparam logic [11:0] RAM_BASE = 12'h000;
    localparam int RAM_BYTES_MIN = 2048;
    localparam int RAM_BYTES_MAX = 4096;
    localparam int PRG_SPACE_BYTES = 65536;
    localparam int FLASH_BYTES_MIN = 16384;
    localparam int FLASH_BYTES_MAX = 65536;
    localparam logic [7:0] UNIMPL_READ = 8'hFF;
    localparam logic [15:0] OPTION_BASE = 16'h0000;
    localparam logic [15:0] RESET_VEC_BASE = 16'h0002;
    localparam logic [15:0] WATCHDOG_VEC_BASE = 16'h0004;
    localparam logic [15:0] TRAP_VEC_BASE = 16'h0006;
    localparam logic [15:0] IRQ_VEC_BASE = 16'h0008;
    localparam logic [15:0] IRQ_VEC_TOP = 16'h0037;
    localparam logic [15:0] CODE_BASE = 16'h0038;
    localparam int INFO_BYTES = 512;
    localparam logic [15:0] INFO_BASE = 16'hFE00;
    localparam logic [15:0] INFO_TOP = 16'hFFFF;
    localparam int INFO_ENABLE_BIT = 7;
    localparam logic [15:0] PART_BASE = 16'hFE40;
    localparam logic [15:0] PART_TOP = 16'hFE53;
    localparam int PART_LEN = 20;
    localparam logic [7:0] RESERVED_READ = 8'hFF;
    // Arbitrary neutral part string, null padded
    localparam logic [8*PART_LEN-1:0] PART_STRING =
        {8'h41, 8'h53, 8'h44, 8'h2D, 8'h30, 8'h30, 8'h31, {13{8'h00}}};
    typedef enum logic [1:0] {
        RS_RAM = 2'b00,
        RS_HOLE = 2'b01,
        RS_CTRL = 2'b10
    } asd_reg_sel_type;
    typedef enum logic [1:0] {
        PS_FLASH = 2'b00,
        PS_UNIMPL = 2'b01,
        PS_INFO = 2'b10
    } asd_prg_sel_type;
endpackage

// *** verilog/asd_info_rom.sv ***
/*
 Read-only information area. Holds the part string and reserved bytes.
 Assumes a 9-bit offset into the 512-byte area; no write port exists.
*/
`timescale 1ns/1ps
module asd_info_rom (
    // Lookup
    input wire logic [8:0] offset,
    output logic [7:0] data
);
    localparam logic [8:0] PART_OFF = 9'(asd_pkg::PART_BASE - asd_pkg::INFO_BASE);
    localparam logic [8:0] PART_END = 9'(asd_pkg::PART_TOP - asd_pkg::INFO_BASE);
    logic [8:0] idx;

    // Left justified: byte 0 of the string is the leftmost character; see RULE16
    always_comb begin
        idx = offset - PART_OFF;
        if (offset >= PART_OFF && offset <= PART_END) begin
            data = asd_pkg::PART_STRING[(asd_pkg::PART_LEN - 1 - idx[4:0]) * 8 +: 8];
        end else begin
            data = asd_pkg::RESERVED_READ;
        end
    end
endmodule

// *** verilog/asd_decoder.sv ***
/*
 Address space decoder: register file, program space, data space and the
 switchable information overlay. Storage arrays are held here.
 Assumes a core issuing one access per cycle with read data one cycle later
 (two for the control page), and that the control-register page lives outside
 this block and answers combinationally during the ctrl_rd pulse.
*/
// Overview of operation
// RULE1: Register space is 4096 bytes: RAM section plus control section.
// RULE2: Top 256 bytes F00H-FFFH go to the control register port.
// RULE3: Reserved control locations read undefined; software should not write them.
// RULE4: RAM starts at 000H, size 2 KB to 4 KB by variant.
// RULE5: Holes between RAM and control page read undefined and ignore writes.
// RULE6: Program space is 64 KB with 16 KB to 64 KB flash from bottom.
// RULE7: Program reads above flash return FFH; writes there do nothing.
// RULE8: Bottom layout: options, reset, watchdog, trap, interrupt vectors, code.
// RULE9: Data-memory accesses reach no storage.
// RULE10: Information area enabled only while page-select bit 7 is 1.
// RULE11: Enabled overlay covers FE00H-FFFFH.
// RULE12: Constant loads in overlay range return information bytes when enabled.
// RULE13: Debug reads in overlay range return information bytes when enabled.
// RULE14: Instruction fetches always return flash contents.
// RULE15: Information area is read-only.
// RULE16: FE40H-FE53H hold null-padded 20-character part string; rest reserved.
// RULE17: With overlay disabled, FE00H-FFFFH behave as any program address.
`timescale 1ns/1ps
module asd_decoder #(
    parameter int RAM_BYTES = asd_pkg::RAM_BYTES_MAX,
    parameter int FLASH_BYTES = asd_pkg::FLASH_BYTES_MAX
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Page select from the core
    input wire logic [7:0] page_select,
    // Register file access
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Control page port to peripherals
    output logic ctrl_rd,
    output logic ctrl_wr,
    output logic [7:0] ctrl_addr,
    output logic [7:0] ctrl_wdata,
    input wire logic [7:0] ctrl_rdata,
    // Program space access
    input wire logic prg_fetch,
    input wire logic prg_const_load,
    input wire logic prg_debug_rd,
    input wire logic prg_wr,
    input wire logic [15:0] prg_addr,
    input wire logic [7:0] prg_wdata,
    output logic [7:0] prg_rdata,
    // Decoded layout of the last program address read or fetched; writes leave it unchanged
    output logic prg_in_vectors,
    // Data memory space
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [15:0] data_addr,
    output logic [7:0] data_rdata
);
    typedef struct packed {
        logic [7:0] reg_rdata;
        logic ctrl_rd;
        logic ctrl_wr;
        logic [7:0] ctrl_addr;
        logic [7:0] ctrl_wdata;
        logic ctrl_pending;
        logic [7:0] prg_rdata;
        logic prg_in_vectors;
        logic [7:0] data_rdata;
    } asd_state_type;

    asd_state_type st_q;
    asd_state_type st_d;

    logic [7:0] ram_mem [RAM_BYTES];
    logic [7:0] flash_mem [FLASH_BYTES];
    logic [8:0] info_off;
    logic [7:0] info_byte;
    asd_pkg::asd_reg_sel_type reg_sel;
    asd_pkg::asd_prg_sel_type prg_sel;
    logic info_en;
    logic ram_we;
    logic flash_we;

    assign info_off = prg_addr[8:0];

    asd_info_rom u_info (
        .offset(info_off),
        .data(info_byte)
    );

    assign info_en = page_select[asd_pkg::INFO_ENABLE_BIT]; // see RULE10

    // Register space select; 12-bit address spans exactly 4096 bytes. see RULE1
    always_comb begin
        if (reg_addr >= asd_pkg::CTRL_PAGE_BASE) begin
            reg_sel = asd_pkg::RS_CTRL; // see RULE2
        end else if (32'(reg_addr) < RAM_BYTES) begin
            reg_sel = asd_pkg::RS_RAM; // see RULE4
        end else begin
            reg_sel = asd_pkg::RS_HOLE; // see RULE5
        end
    end

    // Program space select. Fetches never see the overlay. see RULE14
    always_comb begin
        if (info_en && !prg_fetch && (prg_const_load || prg_debug_rd)
                && prg_addr >= asd_pkg::INFO_BASE) begin
            prg_sel = asd_pkg::PS_INFO; // see RULE11 see RULE12 see RULE13
        end else if (32'(prg_addr) < FLASH_BYTES) begin
            prg_sel = asd_pkg::PS_FLASH; // see RULE6 see RULE17
        end else begin
            prg_sel = asd_pkg::PS_UNIMPL; // see RULE7
        end
    end

    // Writes into RAM only; holes and the information area drop them. see RULE5
    assign ram_we = reg_wr && reg_sel == asd_pkg::RS_RAM;
    // Flash writes model programming; never land in the overlay. see RULE15 see RULE7
    assign flash_we = prg_wr && 32'(prg_addr) < FLASH_BYTES;

    // Arrays kept outside the state struct; contents have no reset, like real RAM
    always_ff @(posedge sys_clk) begin
        if (ram_we) begin
            ram_mem[reg_addr[$clog2(RAM_BYTES)-1:0]] <= reg_wdata;
        end
        if (flash_we) begin
            flash_mem[prg_addr[$clog2(FLASH_BYTES)-1:0]] <= prg_wdata;
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.ctrl_rd = 1'b0;
        st_d.ctrl_wr = 1'b0;
        // Control page forwarded; reserved holes there are the peripherals' concern
        if ((reg_rd || reg_wr) && reg_sel == asd_pkg::RS_CTRL) begin
            st_d.ctrl_rd = reg_rd; // see RULE2
            st_d.ctrl_wr = reg_wr; // see RULE3
            st_d.ctrl_addr = reg_addr[7:0];
            st_d.ctrl_wdata = reg_wdata;
        end
        st_d.ctrl_pending = reg_rd && reg_sel == asd_pkg::RS_CTRL;
        // Peripheral answer is captured in the pulse cycle, so it lands one cycle after RAM data
        if (st_q.ctrl_pending) begin
            st_d.reg_rdata = ctrl_rdata; // see RULE2
        end
        // A new read issued in that answer cycle takes the output instead
        if (reg_rd) begin
            if (reg_sel == asd_pkg::RS_RAM) begin
                st_d.reg_rdata = ram_mem[reg_addr[$clog2(RAM_BYTES)-1:0]]; // see RULE4
            end else begin
                // Undefined value chosen as all ones. see RULE5
                st_d.reg_rdata = asd_pkg::UNIMPL_READ;
            end
        end
        if (prg_fetch || prg_const_load || prg_debug_rd) begin
            if (prg_sel == asd_pkg::PS_INFO) begin
                st_d.prg_rdata = info_byte; // see RULE12 see RULE16
            end else if (prg_sel == asd_pkg::PS_UNIMPL) begin
                st_d.prg_rdata = asd_pkg::UNIMPL_READ; // see RULE7
            end else begin
                st_d.prg_rdata = flash_mem[prg_addr[$clog2(FLASH_BYTES)-1:0]]; // see RULE6
            end
            // Option bits through interrupt vectors sit below the code base. see RULE8
            st_d.prg_in_vectors = prg_addr < asd_pkg::CODE_BASE;
        end
        // Data space is empty: reads give all ones, writes vanish. see RULE9
        if (data_rd || data_wr || data_addr != 16'h0000) begin
            st_d.data_rdata = asd_pkg::UNIMPL_READ;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.data_rdata <= asd_pkg::UNIMPL_READ;
        end else begin
            st_q <= st_d;
        end
    end

    // Read data is held in the state register so every output comes from a flip-flop
    assign reg_rdata = st_q.reg_rdata;
    assign prg_rdata = st_q.prg_rdata;
    assign ctrl_rd = st_q.ctrl_rd;
    assign ctrl_wr = st_q.ctrl_wr;
    assign ctrl_addr = st_q.ctrl_addr;
    assign ctrl_wdata = st_q.ctrl_wdata;
    assign prg_in_vectors = st_q.prg_in_vectors;
    assign data_rdata = st_q.data_rdata;
endmodule

// *** tb/asd_decoder_props.sv ***
/*
 Port checker for the address space decoder.
 Assumes it is bound onto asd_decoder and given the same size parameters.
*/
`timescale 1ns/1ps
module asd_decoder_props #(
    parameter int RAM_BYTES = 4096,
    parameter int FLASH_BYTES = 65536
) (
    input wire logic sys_clk, nrst, reg_rd, reg_wr, ctrl_rd, ctrl_wr,
    input wire logic prg_fetch, prg_const_load, prg_debug_rd, prg_in_vectors,
    input wire logic [7:0] page_select, reg_wdata, reg_rdata, ctrl_addr, ctrl_wdata,
    input wire logic [7:0] prg_rdata, data_rdata,
    input wire logic [11:0] reg_addr,
    input wire logic [15:0] prg_addr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire ctl = reg_addr >= 12'hF00;
    wire crd = prg_const_load || prg_debug_rd;
    // Fetch wins over a constant load, so it never sees the overlay
    wire ovl = !prg_fetch && crd && page_select[7] && prg_addr >= 16'hFE00;
    wire prd = prg_fetch || crd;
    wire part = prg_addr >= 16'hFE40 && prg_addr <= 16'hFE53;
    function automatic logic [7:0] part_byte(input logic [15:0] a);
        return 8'(asd_pkg::PART_STRING >> (8 * (asd_pkg::PART_LEN - 1 - int'(a - 16'hFE40))));
    endfunction
    a_ctrl_write: assert property (reg_wr && ctl |=> ctrl_wr &&
        $past(reg_addr) == {4'hF, ctrl_addr} && ctrl_wdata == $past(reg_wdata))
        else $error("control write not forwarded");
    a_ctrl_read: assert property (reg_rd && ctl |=> ctrl_rd &&
        $past(reg_addr) == {4'hF, ctrl_addr}) else $error("control read not forwarded");
    a_ram_local: assert property ((reg_rd || reg_wr) && !ctl |=> !ctrl_rd && !ctrl_wr)
        else $error("ram access leaked to control port");
    a_hole_read: assert property (reg_rd && !ctl && reg_addr >= RAM_BYTES |=> reg_rdata == 8'hFF)
        else $error("hole read not FF");
    a_unimpl_read: assert property (prd && !ovl && prg_addr >= FLASH_BYTES |=> prg_rdata == 8'hFF)
        else $error("unfitted program read not FF");
    a_part_read: assert property (ovl && part |=> prg_rdata == part_byte($past(prg_addr)))
        else $error("part string byte wrong");
    a_info_rsvd: assert property (ovl && !part |=> prg_rdata == 8'hFF)
        else $error("reserved info byte not FF");
    a_vector_flag: assert property (prd |=> prg_in_vectors == ($past(prg_addr) < 16'h0038))
        else $error("vector flag wrong");
    a_data_empty: assert property (data_rdata == 8'hFF) else $error("data space not empty");
    c_ctrl_write: cover property (ctrl_wr);
    c_overlay: cover property (ovl && part);
    c_hole: cover property (reg_rd && !ctl && reg_addr >= RAM_BYTES);
endmodule
bind asd_decoder asd_decoder_props #(.RAM_BYTES(RAM_BYTES), .FLASH_BYTES(FLASH_BYTES)) u_props (
    .sys_clk(sys_clk), .nrst(nrst), .reg_rd(reg_rd), .reg_wr(reg_wr), .ctrl_rd(ctrl_rd),
    .ctrl_wr(ctrl_wr), .prg_fetch(prg_fetch), .prg_const_load(prg_const_load),
    .prg_debug_rd(prg_debug_rd), .prg_in_vectors(prg_in_vectors), .page_select(page_select),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ctrl_addr(ctrl_addr),
    .ctrl_wdata(ctrl_wdata), .prg_rdata(prg_rdata), .data_rdata(data_rdata),
    .reg_addr(reg_addr), .prg_addr(prg_addr));

// *** tb/asd_ctrl_model.sv ***
/*
 Model of the peripheral control registers behind the control page port.
 Assumes read data is wanted only during the read pulse itself.
*/
`timescale 1ns/1ps
module asd_ctrl_model (
    input wire logic sys_clk, nrst, ctrl_rd, ctrl_wr,
    input wire logic [7:0] ctrl_addr, ctrl_wdata,
    output logic [7:0] ctrl_rdata
);
    logic [7:0] regs_q [256];
    logic [7:0] junk_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            junk_q <= 8'h5A;
        end else begin
            junk_q <= ~junk_q;
            if (ctrl_wr) regs_q[ctrl_addr] <= ctrl_wdata;
        end
    end
    // Outside the answer cycle the bus toggles so stale data cannot pass
    assign ctrl_rdata = ctrl_rd ? regs_q[ctrl_addr] : junk_q;
endmodule

// *** tb/address_space_decoder_test.sv ***
/*
 Testbench for the address space decoder with small RAM and flash variants.
 Assumes the control page is served by asd_ctrl_model.
*/
`timescale 1ns/1ps
module address_space_decoder_test;
    logic sys_clk = 0, nrst = 0, reg_rd = 0, reg_wr = 0, prg_fetch = 0, prg_const_load = 0;
    logic prg_debug_rd = 0, prg_wr = 0, data_rd = 0, data_wr = 0, ctrl_rd, ctrl_wr, prg_in_vectors;
    logic [7:0] page_select = 0, reg_wdata = 0, prg_wdata = 0, reg_rdata, ctrl_addr;
    logic [7:0] ctrl_wdata, ctrl_rdata, prg_rdata, data_rdata;
    logic [11:0] reg_addr = 0;
    logic [15:0] prg_addr = 0, data_addr = 0;
    int err_count = 0, compares = 0;
    always #5 sys_clk = ~sys_clk;
    asd_decoder #(.RAM_BYTES(2048), .FLASH_BYTES(16384)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .page_select(page_select), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ctrl_rd(ctrl_rd), .ctrl_wr(ctrl_wr),
        .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
        .prg_fetch(prg_fetch), .prg_const_load(prg_const_load), .prg_debug_rd(prg_debug_rd),
        .prg_wr(prg_wr), .prg_addr(prg_addr), .prg_wdata(prg_wdata), .prg_rdata(prg_rdata),
        .prg_in_vectors(prg_in_vectors), .data_rd(data_rd), .data_wr(data_wr),
        .data_addr(data_addr), .data_rdata(data_rdata));
    asd_ctrl_model u_ctrl (.sys_clk(sys_clk), .nrst(nrst), .ctrl_rd(ctrl_rd), .ctrl_wr(ctrl_wr),
        .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One-cycle strobe; returns in the answer cycle
    task automatic reg_acc(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {reg_rd, reg_wr, reg_addr, reg_wdata} = {!wr, wr, a, d};
        @(negedge sys_clk);
        {reg_rd, reg_wr} = 2'b00;
    endtask
    task automatic prg_acc(input int k, input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {prg_fetch, prg_const_load, prg_debug_rd, prg_wr} = 4'b1000 >> k;
        {prg_addr, prg_wdata} = {a, d};
        @(negedge sys_clk);
        {prg_fetch, prg_const_load, prg_debug_rd, prg_wr} = 4'b0000;
    endtask
    task automatic t_ram;
        reg_acc(1, 12'h000, 8'h3C);
        reg_acc(1, 12'h7FF, 8'hC3);
        reg_acc(1, 12'h800, 8'h99);
        reg_acc(0, 12'h000, 8'h00);
        chk("ram low", reg_rdata, 8'h3C);
        reg_acc(0, 12'h7FF, 8'h00);
        chk("ram top", reg_rdata, 8'hC3);
        reg_acc(0, 12'hEFF, 8'h00);
        chk("hole", reg_rdata, 8'hFF);
    endtask
    task automatic t_ctrl;
        // Only defined control locations are written
        reg_acc(1, 12'hF05, 8'hA5);
        chk("ctrl wr", ctrl_wr, 1'b1);
        chk("ctrl addr", ctrl_addr, 8'h05);
        chk("ctrl data", ctrl_wdata, 8'hA5);
        reg_acc(1, 12'hFFF, 8'h5A);
        chk("ctrl top", ctrl_addr, 8'hFF);
        reg_acc(0, 12'hF05, 8'h00);
        chk("ctrl rd", ctrl_rd, 1'b1);
        @(negedge sys_clk);
        chk("ctrl rdata", reg_rdata, 8'hA5);
    endtask
    task automatic t_prg;
        prg_acc(3, 16'h0038, 8'h3C);
        prg_acc(3, 16'h3FFF, 8'h77);
        prg_acc(3, 16'h4000, 8'h12);
        prg_acc(1, 16'h0038, 8'h00);
        chk("code", prg_rdata, 8'h3C);
        chk("not vec", prg_in_vectors, 1'b0);
        prg_acc(0, 16'h3FFF, 8'h00);
        chk("flash top", prg_rdata, 8'h77);
        prg_acc(2, 16'h4000, 8'h00);
        chk("unfitted", prg_rdata, 8'hFF);
        prg_acc(0, 16'h0037, 8'h00);
        chk("vec", prg_in_vectors, 1'b1);
    endtask
    task automatic t_info;
        page_select = 8'h80;
        prg_acc(3, 16'hFE40, 8'h00);
        for (int i = 0; i < 20; i++) begin
            prg_acc(1 + i % 2, 16'hFE40 + 16'(i), 8'h00);
            chk("part", prg_rdata,
                asd_pkg::PART_STRING[8 * (asd_pkg::PART_LEN - i) - 1 -: 8]);
        end
        prg_acc(2, 16'hFE00, 8'h00);
        chk("info rsvd", prg_rdata, 8'hFF);
        prg_acc(0, 16'hFE40, 8'h00);
        chk("fetch", prg_rdata, 8'hFF);
        page_select = 8'h7F;
        prg_acc(1, 16'hFE40, 8'h00);
        chk("off", prg_rdata, 8'hFF);
    endtask
    task automatic t_data;
        @(negedge sys_clk);
        {data_wr, data_addr} = {1'b1, 16'h0100};
        @(negedge sys_clk);
        {data_wr, data_rd} = 2'b01;
        @(negedge sys_clk);
        data_rd = 1'b0;
        chk("data", data_rdata, 8'hFF);
    endtask
    task automatic conclude;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        chk("reset data", data_rdata, 8'hFF);
        chk("reset ctrl wr", ctrl_wr, 1'b0);
        nrst = 1'b1;
        t_ram;
        t_ctrl;
        t_prg;
        t_info;
        t_data;
        conclude;
    end
endmodule
